// >>> mfx_flash_dev.sv
// Flash-side sequencer for two- and four-line reads with continuous mode and wrap
//
`timescale 1ns/1ns
`include "mfx_consts.svh"
module mfx_flash_dev (
  input wire logic sys_clk,
  input wire logic rst,
  mfx_link_if.dev link,
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic quad_lines_enable_bit,
  output logic cont_read_active,
  output logic [2:0] wrap_setting_bits
);
  // ============================================================
  // Link input synchronisers
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  logic [3:0] io_s1_q, io_s2_q;

  // Two flops per pin; third flop only feeds edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      ck_s1_q <= link.sclk;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      io_s1_q <= link.io_line;
      io_s2_q <= io_s1_q;
    end
  end

  // ============================================================
  // State and datapath registers
  mfx_pkg::mfx_dev_state_e st_q;
  logic [4:0] cnt_q;
  logic quad_q, word_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q;
  logic [7:0] mode_q;
  logic [2:0] wrap_q;
  logic crm_q, crm_quad_q, crm_word_q;
  logic [7:0] sh_q;
  logic [1:0] pos_q;
  logic [3:0] io_out_q, io_oe_q;

  // Link clock edge events only while selected; select edges are not gated
  wire sel = ~cs_s2_q;
  wire rise = ck_s2_q & ~ck_s3_q & sel;
  wire fall = ~ck_s2_q & ck_s3_q & sel;
  wire cs_fall = ~cs_s2_q & cs_s3_q;
  wire cs_rise = cs_s2_q & ~cs_s3_q;

  // Phase lengths depend on line width and read kind
  wire [4:0] addr_clks = quad_q ? `MFX_ADDR_CLKS_QUAD : `MFX_ADDR_CLKS_DUAL;
  wire [4:0] mode_clks = quad_q ? `MFX_MODE_CLKS_QUAD : `MFX_MODE_CLKS_DUAL;
  wire [4:0] dummy_clks = word_q ? `MFX_DUMMY_CLKS_WORD : `MFX_DUMMY_CLKS_QUAD;
  wire [1:0] pos_last = quad_q ? `MFX_BYTE_CLKS_QUAD : `MFX_BYTE_CLKS_DUAL;

  // Shifted values: opcode one bit per clock; address and mode two bits on dual, four on quad; wrap four
  wire [7:0] opc_d = {opc_q[6:0], io_s2_q[0]};
  wire [23:0] addr_sh = quad_q ? {addr_q[19:0], io_s2_q} : {addr_q[21:0], io_s2_q[1:0]};
  wire [7:0] mode_d = quad_q ? {mode_q[3:0], io_s2_q} : {mode_q[5:0], io_s2_q[1:0]};
  wire [7:0] wrap_sh = {opc_q[3:0], io_s2_q};

  // Opcode decode; four-line reads gated by quad enable
  wire op_dual = (opc_d == `MFX_OP_DUAL);
  wire op_quad = (opc_d == `MFX_OP_QUAD) & quad_lines_enable_bit;
  wire op_word = (opc_d == `MFX_OP_WORD) & quad_lines_enable_bit;
  wire op_wrap = (opc_d == `MFX_OP_WRAP);

  // Next read address: wrap inside aligned section or run linearly
  wire wrap_on = quad_q & ~wrap_q[0];
  wire [7:0] wmask = (`MFX_WRAP_MIN << wrap_q[2:1]) - 8'h01;
  wire [7:0] lo_inc = addr_q[7:0] + 8'h01;
  wire [7:0] lo_wrap = (addr_q[7:0] & ~wmask) | (lo_inc & wmask);
  wire [23:0] addr_lin = addr_q + 24'h000001;
  wire [23:0] addr_nxt = wrap_on ? {addr_q[23:8], lo_wrap} : addr_lin;

  // Output chunk: fresh byte from array at byte start, else shifted rest
  wire [7:0] byte_src = (pos_q == 2'h0) ? mem_rdata : sh_q;
  wire [3:0] chunk = quad_q ? byte_src[7:4] : {2'h0, byte_src[7:6]};
  wire [7:0] rest = quad_q ? {byte_src[3:0], 4'h0} : {byte_src[5:0], 2'h0};
  wire last = (st_q == mfx_pkg::DEV_OPC) ? (cnt_q == `MFX_OPC_CLKS - 5'h01) :
              (st_q == mfx_pkg::DEV_ADDR) ? (cnt_q == addr_clks - 5'h01) :
              (st_q == mfx_pkg::DEV_MODE) ? (cnt_q == mode_clks - 5'h01) :
              (st_q == mfx_pkg::DEV_DUMMY) ? (cnt_q == dummy_clks - 5'h01) :
              (cnt_q == `MFX_WRAP_CLKS - 5'h01);

  // ============================================================
  // Command sequencer; deselect always wins and ends the command
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= mfx_pkg::DEV_IDLE;
      cnt_q <= 5'h00;
      quad_q <= 1'b0;
      word_q <= 1'b0;
      opc_q <= 8'h00;
      mode_q <= 8'h00;
      crm_q <= 1'b0;
      crm_quad_q <= 1'b0;
      crm_word_q <= 1'b0;
      wrap_q <= `MFX_WRAP_RST;
    end else if (cs_rise) begin
      st_q <= mfx_pkg::DEV_IDLE;
      cnt_q <= 5'h00;
    end else begin
      case (st_q)
        mfx_pkg::DEV_IDLE: begin
          if (cs_fall) begin
            cnt_q <= 5'h00;
            // Continuous mode: same read kind, address on first clock
            if (crm_q) begin
              st_q <= mfx_pkg::DEV_ADDR;
              quad_q <= crm_quad_q;
              word_q <= crm_word_q;
            end else begin
              st_q <= mfx_pkg::DEV_OPC;
            end
          end
        end
        mfx_pkg::DEV_OPC: begin
          if (rise) begin
            opc_q <= opc_d;
            cnt_q <= cnt_q + 5'h01;
            if (last) begin
              cnt_q <= 5'h00;
              quad_q <= op_quad | op_word | op_wrap;
              word_q <= op_word;
              if (op_dual | op_quad | op_word) begin
                st_q <= mfx_pkg::DEV_ADDR;
              end else if (op_wrap) begin
                st_q <= mfx_pkg::DEV_WRAP;
              end else begin
                st_q <= mfx_pkg::DEV_SKIP;
              end
            end
          end
        end
        mfx_pkg::DEV_ADDR: begin
          if (rise) begin
            cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
            if (last) begin
              st_q <= mfx_pkg::DEV_MODE;
            end
          end
        end
        mfx_pkg::DEV_MODE: begin
          if (rise) begin
            mode_q <= mode_d;
            cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
            if (last) begin
              // Only bits 5:4 count; all-ones reset lands here too
              crm_q <= (mode_d[5:4] == `MFX_SKIP_CODE);
              crm_quad_q <= quad_q;
              crm_word_q <= word_q;
              st_q <= quad_q ? mfx_pkg::DEV_DUMMY : mfx_pkg::DEV_DATA;
            end
          end
        end
        mfx_pkg::DEV_DUMMY: begin
          if (rise) begin
            cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
            if (last) begin
              st_q <= mfx_pkg::DEV_DATA;
            end
          end
        end
        mfx_pkg::DEV_WRAP: begin
          if (rise) begin
            opc_q <= wrap_sh;
            cnt_q <= cnt_q + 5'h01;
            if (last) begin
              wrap_q <= wrap_sh[6:4];
              st_q <= mfx_pkg::DEV_SKIP;
            end
          end
        end
        mfx_pkg::DEV_DATA, mfx_pkg::DEV_SKIP: begin
          st_q <= st_q;
        end
        default: begin
          st_q <= mfx_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Address capture on rising and data output on falling link clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= 24'h000000;
      sh_q <= 8'h00;
      pos_q <= 2'h0;
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
    end else if (cs_rise) begin
      io_oe_q <= 4'h0;
      pos_q <= 2'h0;
    end else if (st_q == mfx_pkg::DEV_ADDR && rise) begin
      addr_q <= addr_sh;
    end else if (st_q == mfx_pkg::DEV_DATA && fall) begin
      // Host has already let go of the lines by this edge
      io_out_q <= chunk;
      io_oe_q <= quad_q ? `MFX_OE_QUAD : `MFX_OE_DUAL;
      sh_q <= rest;
      pos_q <= (pos_q == pos_last) ? 2'h0 : pos_q + 2'h1;
      if (pos_q == 2'h0) begin
        addr_q <= addr_nxt;
      end
    end
  end

  // ============================================================
  // Outputs, all straight from flops
  assign link.dev_io_o = io_out_q;
  assign link.dev_io_oe = io_oe_q;
  assign mem_addr = addr_q;
  assign cont_read_active = crm_q;
  assign wrap_setting_bits = wrap_q;
endmodule // mfx_flash_dev

// >>> mfx_consts.svh
// Constants shared by both ends of the multi-line flash read link
`ifndef MFX_CONSTS_SVH
`define MFX_CONSTS_SVH
// ============================================================
// Opcodes
`define MFX_OP_DUAL 8'hBB
`define MFX_OP_QUAD 8'hEB
`define MFX_OP_WORD 8'hE7
`define MFX_OP_WRAP 8'h77
// ============================================================
// Mode byte and wrap setting
`define MFX_SKIP_CODE 2'h2
`define MFX_WRAP_RST 3'h1
`define MFX_WRAP_MIN 8'h08
`define MFX_WRAP_CLKS 5'h08
// ============================================================
// Clock counts per phase (link clocks)
`define MFX_OPC_CLKS 5'h08
`define MFX_ADDR_CLKS_DUAL 5'h0C
`define MFX_ADDR_CLKS_QUAD 5'h06
`define MFX_MODE_CLKS_DUAL 5'h04
`define MFX_MODE_CLKS_QUAD 5'h02
`define MFX_TX_CLKS_DUAL 5'h10
`define MFX_TX_CLKS_QUAD 5'h08
`define MFX_DUMMY_CLKS_QUAD 5'h04
`define MFX_DUMMY_CLKS_WORD 5'h02
`define MFX_BYTE_CLKS_DUAL 2'h3
`define MFX_BYTE_CLKS_QUAD 2'h1
// ============================================================
// Line masks and timing
`define MFX_OE_SINGLE 4'h1
`define MFX_OE_DUAL 4'h3
`define MFX_OE_QUAD 4'hF
`define MFX_SYS_CLK_NS 10
`define MFX_SCLK_PERIOD_NS 120
`endif

// >>> mfx_pkg.sv
// Types shared by both ends of the multi-line flash read link
package mfx_pkg;
  typedef enum logic [7:0] {
    DEV_IDLE = 8'h01, DEV_OPC = 8'h02, DEV_ADDR = 8'h04, DEV_MODE = 8'h08,
    DEV_DUMMY = 8'h10, DEV_DATA = 8'h20, DEV_WRAP = 8'h40, DEV_SKIP = 8'h80
  } mfx_dev_state_e;
  typedef enum logic [6:0] {
    HST_IDLE = 7'h01, HST_OPC = 7'h02, HST_TX = 7'h04, HST_DUMMY = 7'h08,
    HST_DATA = 7'h10, HST_END = 7'h20, HST_GAP = 7'h40
  } mfx_host_state_e;
  typedef enum logic [2:0] {
    KIND_DUAL = 3'h0, KIND_QUAD = 3'h1, KIND_WORD = 3'h2, KIND_WRAP = 3'h3, KIND_CRST = 3'h4
  } mfx_kind_e;
endpackage

// >>> mfx_link_if.sv
// Serial link between flash host controller and flash read sequencer
`timescale 1ns/1ns
interface mfx_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io_line;
  // Wire level: device driver, else host driver, else weak pull-up
  assign io_line = (dev_io_o & dev_io_oe) | (host_io_o & host_io_oe & ~dev_io_oe) | ~(dev_io_oe | host_io_oe);
  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io_line);
  modport dev (input cs_n, input sclk, input io_line, output dev_io_o, output dev_io_oe);
endinterface

// >>> mfx_flash_host.sv
// Host-side controller that issues multi-line reads, wrap setting and mode reset
`timescale 1ns/1ns
`include "mfx_consts.svh"
module mfx_flash_host #(
  parameter int SCLK_HALF = `MFX_SCLK_PERIOD_NS / (2 * `MFX_SYS_CLK_NS)
) (
  input wire logic sys_clk,
  input wire logic rst,
  mfx_link_if.host link,
  input wire logic req,
  input wire mfx_pkg::mfx_kind_e req_kind,
  input wire logic [23:0] req_addr,
  input wire logic [7:0] req_mode,
  input wire logic [7:0] req_len,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic cont_read
);
  // Device needs several system clocks per link half period
  if (SCLK_HALF < 4 || SCLK_HALF > 255) begin : g_bad_half
    $error("SCLK_HALF out of range");
  end
  localparam logic [7:0] HALF = 8'(SCLK_HALF);

  // ============================================================
  // Input synchroniser for device data
  logic [3:0] io_s1_q, io_s2_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      io_s1_q <= link.io_line;
      io_s2_q <= io_s1_q;
    end
  end

  // ============================================================
  // Registers
  mfx_pkg::mfx_host_state_e st_q;
  mfx_pkg::mfx_kind_e kind_q, crm_kind_q;
  logic [7:0] div_q, len_q, rx_q;
  logic [4:0] cnt_q;
  logic [1:0] pos_q;
  logic [31:0] tx_q;
  logic [7:0] opc_q;
  logic quad_q, crm_q, cs_n_q, sclk_q, busy_q, valid_q, mode_skip_q;
  logic [3:0] io_out_q, io_oe_q;
  logic [7:0] data_q;

  // Link clock divider events
  wire tick_rise = (div_q == HALF - 8'h01);
  wire tick_fall = (div_q == HALF + HALF - 8'h01);
  wire k_read = (kind_q == mfx_pkg::KIND_DUAL) | (kind_q == mfx_pkg::KIND_QUAD) | (kind_q == mfx_pkg::KIND_WORD);
  wire skip_op = crm_q & (req_kind == crm_kind_q) | (req_kind == mfx_pkg::KIND_CRST);
  wire req_quad = (req_kind == mfx_pkg::KIND_CRST) ? (crm_kind_q != mfx_pkg::KIND_DUAL) :
                  (req_kind != mfx_pkg::KIND_DUAL);
  wire [7:0] req_opc = (req_kind == mfx_pkg::KIND_DUAL) ? `MFX_OP_DUAL :
                       (req_kind == mfx_pkg::KIND_QUAD) ? `MFX_OP_QUAD :
                       (req_kind == mfx_pkg::KIND_WORD) ? `MFX_OP_WORD : `MFX_OP_WRAP;
  // Word read always sends an even address
  wire [23:0] a_even = (req_kind == mfx_pkg::KIND_WORD) ? {req_addr[23:1], 1'b0} : req_addr;
  wire [31:0] req_tx = (req_kind == mfx_pkg::KIND_CRST) ? 32'hFFFFFFFF :
                       (req_kind == mfx_pkg::KIND_WRAP) ? {24'h000000, req_mode} : {a_even, req_mode};
  wire [4:0] tx_clks = quad_q ? `MFX_TX_CLKS_QUAD : `MFX_TX_CLKS_DUAL;
  wire [4:0] dum_clks = (kind_q == mfx_pkg::KIND_WORD) ? `MFX_DUMMY_CLKS_WORD : `MFX_DUMMY_CLKS_QUAD;
  wire [3:0] tx_bits = quad_q ? tx_q[31:28] : {2'h0, tx_q[31:30]};
  wire [31:0] tx_nxt = quad_q ? {tx_q[27:0], 4'h0} : {tx_q[29:0], 2'h0};
  wire [7:0] rx_nxt = quad_q ? {rx_q[3:0], io_s2_q} : {rx_q[5:0], io_s2_q[1:0]};
  wire [1:0] pos_last = quad_q ? `MFX_BYTE_CLKS_QUAD : `MFX_BYTE_CLKS_DUAL;
  wire [7:0] op_nxt = {opc_q[6:0], 1'b0};

  // ============================================================
  // Sequencer: bits change on falling link edge, device samples on rising
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= mfx_pkg::HST_IDLE;
      kind_q <= mfx_pkg::KIND_DUAL;
      crm_kind_q <= mfx_pkg::KIND_DUAL;
      div_q <= 8'h00;
      len_q <= 8'h00;
      rx_q <= 8'h00;
      cnt_q <= 5'h00;
      pos_q <= 2'h0;
      tx_q <= 32'h00000000;
      opc_q <= 8'h00;
      quad_q <= 1'b0;
      crm_q <= 1'b0;
      mode_skip_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      busy_q <= 1'b0;
      valid_q <= 1'b0;
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
      data_q <= 8'h00;
    end else begin
      valid_q <= 1'b0;
      div_q <= tick_fall ? 8'h00 : div_q + 8'h01;
      if (tick_rise && st_q != mfx_pkg::HST_END && st_q != mfx_pkg::HST_GAP && st_q != mfx_pkg::HST_IDLE) begin
        sclk_q <= 1'b1;
      end
      case (st_q)
        mfx_pkg::HST_IDLE: begin
          div_q <= 8'h00;
          if (req) begin
            busy_q <= 1'b1;
            cs_n_q <= 1'b0;
            kind_q <= req_kind;
            quad_q <= req_quad;
            tx_q <= req_tx;
            len_q <= req_len;
            cnt_q <= 5'h00;
            pos_q <= 2'h0;
            opc_q <= {req_opc[6:0], 1'b0};
            // Latch the skip decision; the user port need not hold the mode byte
            mode_skip_q <= (req_mode[5:4] == `MFX_SKIP_CODE);
            // Continuous mode: address goes out on the very first clock
            if (skip_op) begin
              st_q <= mfx_pkg::HST_TX;
              io_out_q <= req_quad ? req_tx[31:28] : {2'h0, req_tx[31:30]};
              io_oe_q <= req_quad ? `MFX_OE_QUAD : `MFX_OE_DUAL;
            end else begin
              st_q <= mfx_pkg::HST_OPC;
              io_out_q <= {3'h0, req_opc[7]};
              io_oe_q <= `MFX_OE_SINGLE;
            end
          end
        end
        mfx_pkg::HST_OPC: begin
          if (tick_fall) begin
            sclk_q <= 1'b0;
            cnt_q <= cnt_q + 5'h01;
            opc_q <= op_nxt;
            io_out_q <= {3'h0, opc_q[7]};
            if (cnt_q == `MFX_OPC_CLKS - 5'h01) begin
              st_q <= mfx_pkg::HST_TX;
              cnt_q <= 5'h00;
              io_out_q <= tx_bits;
              io_oe_q <= quad_q ? `MFX_OE_QUAD : `MFX_OE_DUAL;
            end
          end
        end
        mfx_pkg::HST_TX: begin
          if (tick_fall) begin
            sclk_q <= 1'b0;
            cnt_q <= cnt_q + 5'h01;
            tx_q <= tx_nxt;
            io_out_q <= quad_q ? tx_nxt[31:28] : {2'h0, tx_nxt[31:30]};
            if (cnt_q == tx_clks - 5'h01) begin
              cnt_q <= 5'h00;
              io_oe_q <= 4'h0;
              if (k_read) begin
                crm_q <= mode_skip_q;
                crm_kind_q <= kind_q;
                st_q <= quad_q ? mfx_pkg::HST_DUMMY : mfx_pkg::HST_DATA;
              end else begin
                if (kind_q == mfx_pkg::KIND_CRST) crm_q <= 1'b0;
                st_q <= mfx_pkg::HST_END;
              end
            end
          end
        end
        mfx_pkg::HST_DUMMY: begin
          if (tick_fall) begin
            sclk_q <= 1'b0;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == dum_clks - 5'h01) begin
              st_q <= mfx_pkg::HST_DATA;
              cnt_q <= 5'h00;
            end
          end
        end
        mfx_pkg::HST_DATA: begin
          // Sample at the fall that follows the device's drive edge
          if (tick_fall) begin
            sclk_q <= 1'b0;
            rx_q <= rx_nxt;
            pos_q <= (pos_q == pos_last) ? 2'h0 : pos_q + 2'h1;
            if (pos_q == pos_last) begin
              data_q <= rx_nxt;
              valid_q <= 1'b1;
              len_q <= len_q - 8'h01;
              if (len_q == 8'h01) st_q <= mfx_pkg::HST_END;
            end
          end
        end
        mfx_pkg::HST_END: begin
          cs_n_q <= 1'b1;
          if (tick_fall) st_q <= mfx_pkg::HST_GAP;
        end
        mfx_pkg::HST_GAP: begin
          if (tick_fall) begin
            st_q <= mfx_pkg::HST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          st_q <= mfx_pkg::HST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Outputs, all straight from flops
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.host_io_o = io_out_q;
  assign link.host_io_oe = io_oe_q;
  assign busy = busy_q;
  assign rd_data = data_q;
  assign rd_valid = valid_q;
  assign cont_read = crm_q;
endmodule // mfx_flash_host

// >>> mfx_link_chk.sv
// Protocol checker for the serial link between flash host and flash sequencer
`timescale 1ns/1ns
module mfx_link_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ============================================================
  // Framing: the link clock only moves inside a frame
  idle_clk_low_a: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("link clock moved while deselected");
  start_clk_low_a: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
    else $error("frame opened with clock high");
  end_clk_low_a: assert property ($rose(cs_n) |-> !sclk)
    else $error("frame closed with clock high");
  // Short high phases would outrun the sequencer's two-flop sync
  clk_high_min_a: assert property ($rose(sclk) |-> sclk [*4])
    else $error("link clock high phase too short");
  // ============================================================
  // Line ownership: never two drivers on one line
  no_contention_a: assert property ((dev_io_oe & host_io_oe) == 4'h0)
    else $error("host and device drive together");
  host_released_a: assert property ($rose(dev_io_oe != 4'h0) |-> $past(host_io_oe) == 4'h0 && !cs_n)
    else $error("host still drove when device started");
  dev_release_a: assert property ($rose(cs_n) |-> ##[1:6] dev_io_oe == 4'h0)
    else $error("device kept driving after deselect");
  dev_idle_quiet_a: assert property (cs_n [*8] |-> dev_io_oe == 4'h0)
    else $error("device drives while idle");
  dev_lines_a: assert property (dev_io_oe != 4'h0 |-> dev_io_oe == 4'h3 || dev_io_oe == 4'hF)
    else $error("device drives an odd set of lines");
  // Data may only change while the clock is low
  data_stable_a: assert property (sclk && $past(sclk) && dev_io_oe != 4'h0 |-> $stable(dev_io_o))
    else $error("device data moved in clock high phase");
endmodule // mfx_link_chk

// >>> multi_io_flash_read_xip_test.sv
// Self-checking bench joining the flash host controller to the flash sequencer
`timescale 1ns/1ns
module multi_io_flash_read_xip_test;
  logic sys_clk, rst, req, qe, busy, rd_valid, cont_read, cont_read_active;
  mfx_pkg::mfx_kind_e req_kind;
  logic [23:0] req_addr, mem_addr;
  logic [7:0] req_mode, req_len, rd_data, mem_rdata;
  logic [2:0] wrap_setting_bits, wrap_q;
  int mismatches, total_checks, edges, w;
  mfx_link_if link ();
  mfx_flash_host mfx_flash_host_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .req(req), .req_kind(req_kind),
    .req_addr(req_addr), .req_mode(req_mode), .req_len(req_len), .busy(busy), .rd_data(rd_data),
    .rd_valid(rd_valid), .cont_read(cont_read));
  mfx_flash_dev mfx_flash_dev_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .quad_lines_enable_bit(qe), .cont_read_active(cont_read_active),
    .wrap_setting_bits(wrap_setting_bits));
  mfx_link_chk mfx_link_chk_inst (.sys_clk(sys_clk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
    .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o), .dev_io_oe(link.dev_io_oe));
  // ============================================================
  // Array model: address-dependent pattern so misaddressing shows
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  assign mem_rdata = pat(mem_addr);
  // System clock and counter of rising link clock edges inside a frame
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge link.sclk) if (link.cs_n === 1'b0) edges++;
  // ============================================================
  // Compare helper
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // One host command; bytes, link clock count and mode flags are compared
  task automatic run(input mfx_pkg::mfx_kind_e k, input logic [23:0] a, input logic [7:0] m,
    input logic [7:0] n, input int exp_edges, input logic exp_cont);
    logic [23:0] ea, lin, wr;
    logic [7:0] sz;
    logic wrap_on;
    int got, cyc;
    ea = (k == mfx_pkg::KIND_WORD) ? {a[23:1], 1'b0} : a;
    sz = 8'h08 << wrap_q[2:1];
    wrap_on = (k == mfx_pkg::KIND_QUAD || k == mfx_pkg::KIND_WORD) && !wrap_q[0];
    got = 0;
    edges = 0;
    req_kind <= k;
    req_addr <= a;
    req_mode <= m;
    req_len <= n;
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    @(negedge sys_clk);
    for (cyc = 0; cyc < 4000 && busy !== 1'b0; cyc++) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1) begin
        lin = ea + got[23:0];
        wr = {ea[23:8], (ea[7:0] & ~(sz - 8'h01)) | (lin[7:0] & (sz - 8'h01))};
        chk(rd_data, (qe !== 1'b1 && k != mfx_pkg::KIND_DUAL) ? 8'hFF : pat(wrap_on ? wr : lin), "byte");
        got++;
      end
    end
    // A command that never ends counts as a mismatch here
    chk(busy, 1'b0, "command finished");
    chk(got, (k == mfx_pkg::KIND_WRAP || k == mfx_pkg::KIND_CRST) ? 0 : n, "byte count");
    chk(edges, exp_edges, "link clocks");
    chk(cont_read_active, exp_cont, "device mode");
    chk(cont_read, exp_cont, "host mode");
    if (k == mfx_pkg::KIND_WRAP) begin
      wrap_q = m[6:4];
      chk(wrap_setting_bits, m[6:4], "wrap bits");
    end
    $display("done kind %0d addr %0h", k, a);
    @(posedge sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ============================================================
  // Watchdog sized well beyond the command list
  initial begin
    #600000;
    mismatches++;
    $display("FAIL %0t watchdog expired", $time);
    tally_and_finish();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    req = 1'b0;
    qe = 1'b0;
    req_kind = mfx_pkg::KIND_DUAL;
    req_addr = 24'h000000;
    req_mode = 8'h00;
    req_len = 8'h01;
    wrap_q = 3'h1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(wrap_setting_bits, 3'h1, "wrap reset");
    chk(cont_read_active, 1'b0, "mode reset");
    @(posedge sys_clk);
    run(mfx_pkg::KIND_DUAL, 24'h012345, 8'h00, 8'h03, 36, 1'b0);
    run(mfx_pkg::KIND_DUAL, 24'h0123FE, 8'hA3, 8'h02, 32, 1'b1);
    run(mfx_pkg::KIND_DUAL, 24'h00FFFF, 8'h20, 8'h02, 24, 1'b1);
    run(mfx_pkg::KIND_DUAL, 24'h000010, 8'h00, 8'h01, 20, 1'b0);
    // Host cannot see quad enable, so this refused read must not arm continuous mode
    run(mfx_pkg::KIND_QUAD, 24'h000200, 8'h00, 8'h02, 24, 1'b0);
    qe <= 1'b1;
    run(mfx_pkg::KIND_QUAD, 24'h000200, 8'h20, 8'h02, 24, 1'b1);
    run(mfx_pkg::KIND_QUAD, 24'h000300, 8'hF0, 8'h01, 14, 1'b0);
    run(mfx_pkg::KIND_WORD, 24'h000207, 8'h20, 8'h02, 22, 1'b1);
    run(mfx_pkg::KIND_WORD, 24'h000411, 8'h25, 8'h01, 12, 1'b1);
    run(mfx_pkg::KIND_CRST, 24'h000000, 8'hFF, 8'h00, 8, 1'b0);
    run(mfx_pkg::KIND_WORD, 24'h000500, 8'h00, 8'h01, 20, 1'b0);
    // Every section length, alternating the two four-line reads
    for (w = 0; w < 4; w++) begin
      run(mfx_pkg::KIND_WRAP, 24'h000000, {1'b0, w[1:0], 5'h0F}, 8'h00, 16, 1'b0);
      if (w[0]) run(mfx_pkg::KIND_WORD, 24'h00013E, 8'h00, 8'h0A, 38, 1'b0);
      else run(mfx_pkg::KIND_QUAD, 24'h00013E, 8'h00, 8'h0A, 40, 1'b0);
    end
    run(mfx_pkg::KIND_DUAL, 24'h00013F, 8'h00, 8'h02, 32, 1'b0);
    run(mfx_pkg::KIND_WRAP, 24'h000000, 8'h10, 8'h00, 16, 1'b0);
    run(mfx_pkg::KIND_QUAD, 24'h00013F, 8'h00, 8'h02, 24, 1'b0);
    qe <= 1'b0;
    run(mfx_pkg::KIND_WORD, 24'h000600, 8'h00, 8'h01, 20, 1'b0);
    tally_and_finish();
  end
endmodule // multi_io_flash_read_xip_test
